// ===== dv/core_model.sv
/*
  Word-side core model: registers and FIFOs as one plain memory.
  Assumes reads are answered combinationally in the core_rd cycle.
*/
module core_model (
  // Clock
  input wire logic        mclk,
  // Word side
  input wire logic        core_wr,
  input wire logic        core_rd,
  input wire logic [7:2]  core_addr,
  input wire logic [31:0] core_wdata,
  output logic     [31:0] core_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_r [64];
  // Only whole committed words land here
  always_ff @(posedge mclk) begin
    if (core_wr) mem_r[core_addr] <= core_wdata;
  end
  // Outside a fetch the bus shows junk, so stale use shows up
  assign core_rdata = core_rd ? mem_r[core_addr] : ~mem_r[core_addr];
endmodule

// ===== dv/hbus_checker_assertions.sv
/*
  Port checker for the width adapter, bound onto its top module.
  Assumes one clock, mclk, and srst synchronous active high.
*/
module hbus_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Host side
  input wire logic        host_cs_n,
  input wire logic        host_rd_n,
  input wire logic        host_wr_n,
  input wire logic [31:0] data_o,
  input wire logic [1:0]  data_oe,
  // Core side and mode
  input wire logic        core_wr,
  input wire logic        core_rd,
  input wire logic        bus16_mode,
  input wire logic        swap_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  upper_oe_off_a: assert property (bus16_mode |-> !data_oe[1])
    else $error("upper lanes enabled in 16-bit mode");
  upper_data_zero_a: assert property (
    bus16_mode |-> data_o[31:16] == 16'h0)
    else $error("upper data not zero in 16-bit mode");
  // Order only moves on a write close: three edges after the strobe is released
  swap_on_commit_a: assert property (
    $changed(swap_mode) |-> !$past(host_wr_n, 4) && $past(host_wr_n, 3))
    else $error("swap mode changed without a write close");
  both_lanes_a: assert property (
    !bus16_mode && data_oe[0] |-> data_oe[1])
    else $error("32-bit read drives one lane only");
  wr_pulse_a: assert property (core_wr |=> !core_wr)
    else $error("word commit longer than one cycle");
  wr_after_release_a: assert property (
    $rose(core_wr) |-> host_wr_n)
    else $error("word committed while strobe active");
  oe_on_read_a: assert property (
    $rose(data_oe[0]) |-> !host_rd_n && !host_cs_n)
    else $error("lanes driven without a read");
  oe_hold_a: assert property (
    data_oe[0] && !host_rd_n && !host_cs_n |=> data_oe[0])
    else $error("lanes dropped during a read");
  wr_rd_excl_a: assert property (!(core_wr && core_rd))
    else $error("commit and fetch together");

  commit16_c: cover property (core_wr && bus16_mode);
  fetch_c: cover property (core_rd);
  swap_c: cover property (swap_mode && data_oe[0]);
endmodule

bind host_port_width_adapter hbus_checker i_hbus_checker (
  .mclk, .srst, .host_cs_n, .host_rd_n, .host_wr_n, .data_o,
  .data_oe, .core_wr, .core_rd, .bus16_mode, .swap_mode);

// ===== dv/tb.sv
/*
  Bench for the width adapter: 32-bit strap first, then 16-bit.
  Assumes the core model answers core_rd in the same cycle.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        cs_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        wr_n = 1'b1;
  logic        strap = 1'b0;
  logic        oe_q = 1'b0;
  logic [7:1]  addr = 7'h00;
  logic [31:0] din = 32'h0;
  logic [31:0] dout, cwd, crdata, w, x;
  logic [1:0]  oe;
  logic [7:2]  cad;
  logic        cwr, crd, b16, swp;
  logic [37:0] wq [$];
  logic [32:0] rq [$];
  int          error_cnt = 0;
  int          checks_done = 0;

  always #12.5 mclk = ~mclk;

  host_port_width_adapter i_host_port_width_adapter (
    .mclk(mclk), .srst(srst), .ce(ce), .host_cs_n(cs_n),
    .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr(addr),
    .data_i(din), .data_o(dout), .data_oe(oe),
    .width_strap_pin(strap), .core_wr(cwr), .core_rd(crd),
    .core_addr(cad), .core_wdata(cwd), .core_rdata(crdata),
    .bus16_mode(b16), .swap_mode(swp));

  core_model i_core_model (
    .mclk(mclk), .core_wr(cwr), .core_rd(crd), .core_addr(cad),
    .core_wdata(cwd), .core_rdata(crdata));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Strap is sampled once after release, so each mode needs a reset
  task automatic rst(input logic s);
    srst = 1'b1;
    strap = s;
    cyc(5);
    srst = 1'b0;
    cyc(8);
  endtask

  task automatic hw(input logic [7:0] a, input logic [31:0] d);
    addr = a[7:1];
    din = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(4);
    cs_n = 1'b1;
    wr_n = 1'b1;
    cyc(6);
  endtask

  task automatic h16(input logic [7:0] a, input logic [15:0] h);
    hw(a, {16'h0, h});
  endtask

  task automatic hr(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    addr = a[7:1];
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(8);
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(6);
  endtask

  task automatic r16(input logic [7:0] a, input logic [15:0] h);
    hr(a, {17'h0, h});
  endtask

  // Results are matched to notes when they show at the ports
  always @(posedge mclk) begin
    oe_q <= oe[0];
    if (!srst && cwr !== 1'b0)
      chk({cad, cwd}, wq.size() > 0 ? wq.pop_front() : ~{cad, cwd});
    if (oe_q && !oe[0]) begin
      if (rq.size() == 0)
        chk({6'h0, dout}, ~{6'h0, dout});
      else if (!rq[0][32])
        chk({6'h0, dout}, {5'h0, rq.pop_front()});
      else
        void'(rq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    x = $urandom(32'hc129);
    rst(1'b0);
    chk({37'h0, b16}, 38'h0);
    w = $urandom;
    wq.push_back({6'h04, w});
    hw(8'h10, w);
    hr(8'h10, {1'b0, w});
    hr(8'h54, 33'h0);
    hw(8'h98, 32'hffff_ffff);
    chk({37'h0, swp}, 38'h0);
    hr(8'h98, 33'h0_ffff_ffff);
    hr(8'h10, {1'b0, w});
    rst(1'b1);
    chk({37'h0, b16}, 38'h1);
    r16(8'h54, 16'h0004);
    r16(8'h56, 16'h0000);
    r16(8'h98, 16'h0000);
    r16(8'h9a, 16'h0000);
    w = $urandom;
    wq.push_back({6'h08, w});
    h16(8'h22, w[31:16]);
    // Freeze mid-pair: the buffered half must survive
    ce = 1'b0;
    cyc(3);
    ce = 1'b1;
    h16(8'h20, w[15:0]);
    x = $urandom;
    h16(8'h30, x[15:0]);
    h16(8'h30, x[31:16]);
    wq.push_back({6'h0c, x});
    h16(8'h30, x[15:0]);
    h16(8'h32, x[31:16]);
    r16(8'h22, w[31:16]);
    r16(8'h20, w[15:0]);
    h16(8'h98, 16'hffff);
    h16(8'h9a, 16'hffff);
    chk({37'h0, swp}, 38'h1);
    x = $urandom;
    wq.push_back({6'h0c, x});
    h16(8'h30, x[31:16]);
    h16(8'h32, x[15:0]);
    r16(8'h30, x[31:16]);
    r16(8'h32, x[15:0]);
    h16(8'h98, 16'hfffe);
    h16(8'h9a, 16'hffff);
    chk({37'h0, swp}, 38'h0);
    r16(8'h20, w[15:0]);
    r16(8'h22, w[31:16]);
    r16(8'h30, x[15:0]);
    w = $urandom;
    wq.push_back({6'h0c, w});
    h16(8'h30, w[15:0]);
    h16(8'h32, w[31:16]);
    hr(8'h30, 33'h1_0000_0000);
    r16(8'h32, w[31:16]);
    cyc(4);
    chk(38'(wq.size() + rq.size()), 38'h0);
    report_and_stop();
  end
endmodule

// ===== hdl/halfword_lane_map.sv
/*
  Picks which internal half-word a 16-bit access lands on.
  Assumes the user supplies mode, swap decode and address bit 1.
*/
module halfword_lane_map (
  // Mapping request and answer
  lane_map_if.mapper m
);

  // High half when bit 1 and swap differ, only in 16-bit mode
  always_comb begin
    m.half = m.bus16 & (m.a1 ^ m.swap);
  end

endmodule

// ===== hdl/host_port_width_adapter.sv
/*
  Host data port width adapter: 32-bit native access, or 16-bit
  access paired into whole words with programmable half-word order.
  Assumes host pins are asynchronous and held around strobes, and
  that the core answers core_rdata in the cycle core_rd is high.
*/
module host_port_width_adapter #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ce,
  // Host bus pins
  input  wire logic              host_cs_n,
  input  wire logic              host_rd_n,
  input  wire logic              host_wr_n,
  input  wire logic [ADDR_W-1:1] host_addr,
  input  wire logic [31:0]       data_i,
  output logic      [31:0]       data_o,
  output logic      [1:0]        data_oe,
  // Width strap
  input  wire logic              width_strap_pin,
  // Word side towards registers and FIFOs
  output logic                   core_wr,
  output logic                   core_rd,
  output logic      [ADDR_W-1:2] core_addr,
  output logic      [31:0]       core_wdata,
  input  wire logic [31:0]       core_rdata,
  // Local state seen by the core
  output logic                   bus16_mode,
  output logic                   swap_mode
);

  localparam int          DW    = ADDR_W - 2;
  localparam int          SW    = ADDR_W + 35;
  localparam logic [31:0] CFG_B = hbus_pkg::HW_CONFIG_OFS;
  localparam logic [31:0] ORD_B = hbus_pkg::ORDER_CTRL_OFS;
  localparam logic [SW-1:0] SYNC_INIT = {3'h7, {(SW - 3){1'b0}}};

  typedef struct packed {
    hbus_pkg::rd_state_t st;
    logic [1:0]          strap_cnt;
    logic                strap_done;
    logic                bus16;
    logic [31:0]         order;
    logic                rd_prev;
    logic                wr_prev;
    logic [ADDR_W-1:1]   wa;
    logic [31:0]         wd;
    logic                wpend;
    logic                whalf;
    logic [DW-1:0]       wdw;
    logic [15:0]         wbuf;
    logic                rpend;
    logic                rhalf;
    logic [DW-1:0]       rdw;
    logic [31:0]         rword;
    logic                rsel;
    logic [31:0]         dout;
    logic [1:0]          oe;
    logic                cwr;
    logic                crd;
    logic [DW-1:0]       caddr;
    logic [31:0]         cwdata;
  } port_state_t;

  port_state_t q_r;
  port_state_t q_nxt;

  // Synchronised pins
  logic              s_cs_n;
  logic              s_rd_n;
  logic              s_wr_n;
  logic [ADDR_W-1:1] s_addr;
  logic [31:0]       s_din;
  logic              s_strap;
  logic              rd_act;
  logic              wr_act;
  logic              swap;
  logic [31:0]       cfg_word;

  // Data bits are synchronised one by one; safe only because the
  // host holds them steady for the whole strobe
  pin_sync #(
    .W    (SW),
    .INIT (SYNC_INIT)
  ) u_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .d    ({host_cs_n, host_rd_n, host_wr_n, host_addr, data_i,
            width_strap_pin}),
    .q    ({s_cs_n, s_rd_n, s_wr_n, s_addr, s_din, s_strap})
  );

  assign rd_act = ~s_cs_n & ~s_rd_n;
  assign wr_act = ~s_cs_n & ~s_wr_n;
  assign swap   = (q_r.order == hbus_pkg::SWAP_KEY);

  // Lane mapping for the write being closed and the read opening
  lane_map_if wmap ();
  lane_map_if rmap ();

  assign wmap.bus16 = q_r.bus16;
  assign wmap.swap  = swap;
  assign wmap.a1    = q_r.wa[1];
  assign rmap.bus16 = q_r.bus16;
  assign rmap.swap  = swap;
  assign rmap.a1    = s_addr[1];

  halfword_lane_map u_wmap (
    .m (wmap.mapper)
  );

  halfword_lane_map u_rmap (
    .m (rmap.mapper)
  );

  always_comb begin
    cfg_word                         = '0;
    cfg_word[hbus_pkg::CFG_BUS16_BIT] = q_r.bus16;
  end

  // Places one internal half-word, or the whole word, on the pins
  function automatic logic [31:0] present(
    input logic        b16,
    input logic [31:0] w,
    input logic        hi
  );
    logic [31:0] v;
    v = w;
    if (b16) begin
      v = {16'h0000, hi ? w[31:16] : w[15:0]};
    end
    return v;
  endfunction

  // Local registers answer here; everything else goes to the core
  function automatic logic [31:0] local_word(
    input logic [DW-1:0] a,
    input logic [31:0]   cfg,
    input logic [31:0]   ord
  );
    logic [31:0] v;
    v = '0;
    if (a == CFG_B[ADDR_W-1:2]) begin
      v = cfg;
    end else if (a == ORD_B[ADDR_W-1:2]) begin
      v = ord;
    end
    return v;
  endfunction

  function automatic logic is_local(
    input logic [DW-1:0] a
  );
    return (a == CFG_B[ADDR_W-1:2]) || (a == ORD_B[ADDR_W-1:2]);
  endfunction

  always_comb begin
    logic [DW-1:0] dwa;
    logic [DW-1:0] wdwa;
    logic [31:0]   word;
    logic          commit;
    dwa    = s_addr[ADDR_W-1:2];
    wdwa   = q_r.wa[ADDR_W-1:2];
    word   = q_r.wd;
    commit = 1'b0;

    q_nxt         = q_r;
    q_nxt.cwr     = 1'b0;
    q_nxt.crd     = 1'b0;
    q_nxt.rd_prev = rd_act;
    q_nxt.wr_prev = wr_act;

    // Strap is caught once, after the synchroniser has filled
    if (!q_r.strap_done) begin
      if (q_r.strap_cnt == hbus_pkg::STRAP_SETTLE) begin
        q_nxt.strap_done = 1'b1;
        q_nxt.bus16      = (s_strap == hbus_pkg::STRAP_BUS16);
      end else begin
        q_nxt.strap_cnt = q_r.strap_cnt + 2'h1;
      end
    end

    // Address and data are kept from inside the strobe
    if (wr_act) begin
      q_nxt.wa = s_addr;
      q_nxt.wd = s_din;
    end

    // Write closes on the trailing edge of the strobe
    if (q_r.wr_prev && !wr_act) begin
      if (!q_r.bus16) begin
        commit = 1'b1;
      end else if (q_r.wpend && (q_r.wdw == wdwa)) begin
        q_nxt.wpend = 1'b0;
        if (wmap.half != q_r.whalf) begin
          commit = 1'b1;
          word   = wmap.half ? {q_r.wd[15:0], q_r.wbuf}
                             : {q_r.wbuf, q_r.wd[15:0]};
        end
        // Same half twice: the pair is dropped whole
      end else begin
        // A new pair opens, also when bit 2 upward moved
        q_nxt.wpend = 1'b1;
        q_nxt.whalf = wmap.half;
        q_nxt.wdw   = wdwa;
        q_nxt.wbuf  = q_r.wd[15:0];
      end
    end

    if (commit) begin
      if (wdwa == ORD_B[ADDR_W-1:2]) begin
        q_nxt.order = word;
      end else if (!is_local(wdwa)) begin
        q_nxt.cwr    = 1'b1;
        q_nxt.caddr  = wdwa;
        q_nxt.cwdata = word;
      end
    end

    // Pins are driven only while the host reads; upper lane stays
    // released in 16-bit mode
    q_nxt.oe = {rd_act & ~q_r.bus16, rd_act};

    unique case (q_r.st)
      hbus_pkg::ST_IDLE: begin
        if (rd_act && !q_r.rd_prev) begin
          q_nxt.rsel = rmap.half;
          if (q_r.bus16 && q_r.rpend && (q_r.rdw == dwa)) begin
            // Second half served from the word fetched first; a
            // repeated half returns stale data and ends the pair
            q_nxt.rpend = 1'b0;
            q_nxt.dout  = present(1'b1, q_r.rword, rmap.half);
            q_nxt.st    = hbus_pkg::ST_HOLD;
          end else begin
            q_nxt.rpend = q_r.bus16;
            q_nxt.rhalf = rmap.half;
            q_nxt.rdw   = dwa;
            if (is_local(dwa)) begin
              q_nxt.rword = local_word(dwa, cfg_word, q_r.order);
              q_nxt.dout  = present(q_r.bus16,
                                    local_word(dwa, cfg_word,
                                               q_r.order),
                                    rmap.half);
              q_nxt.st    = hbus_pkg::ST_HOLD;
            end else begin
              q_nxt.crd   = 1'b1;
              q_nxt.caddr = dwa;
              q_nxt.st    = hbus_pkg::ST_FETCH;
            end
          end
        end
      end
      hbus_pkg::ST_FETCH: begin
        q_nxt.rword = core_rdata;
        q_nxt.dout  = present(q_r.bus16, core_rdata, q_r.rsel);
        q_nxt.st    = hbus_pkg::ST_HOLD;
      end
      hbus_pkg::ST_HOLD: begin
        if (!rd_act) begin
          q_nxt.st = hbus_pkg::ST_IDLE;
        end
      end
      default: begin
        q_nxt.st = hbus_pkg::ST_IDLE;
      end
    endcase

    // Same-half repeat within a pair also drops the read tracking
    if (q_r.st == hbus_pkg::ST_IDLE && rd_act && !q_r.rd_prev &&
        q_r.rpend && q_r.rdw == dwa && q_r.rhalf == rmap.half) begin
      q_nxt.rpend = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q_r       <= '0;
      q_r.st    <= hbus_pkg::ST_IDLE;
      q_r.order <= hbus_pkg::ORDER_RST;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  // Outputs
  assign data_o     = q_r.dout;
  assign data_oe    = q_r.oe;
  assign core_wr    = q_r.cwr;
  assign core_rd    = q_r.crd;
  assign core_addr  = q_r.caddr;
  assign core_wdata = q_r.cwdata;
  assign bus16_mode = q_r.bus16;
  assign swap_mode  = swap & q_r.bus16;

endmodule

// ===== hdl/pin_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the group is held stable by the host around its strobes.
*/
module pin_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock, reset, enable
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r_r;
  sync_t r_nxt;

  // First stage feeds only the second
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r_r <= {INIT, INIT};
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.s2;

endmodule

// ===== inc/hbus_pkg.sv
/*
  Constants for the host data port width adapter: register offsets,
  field positions, reset values, state codes and strap timing.
  Assumes every user writes hbus_pkg::name and imports nothing.
*/
package hbus_pkg;

  // Host byte addresses of the locally held registers
  localparam logic [31:0] HW_CONFIG_OFS  = 32'h0000_0054;
  localparam logic [31:0] ORDER_CTRL_OFS = 32'h0000_0098;

  // Field layout and reset values
  localparam int          CFG_BUS16_BIT  = 2;
  localparam logic [31:0] ORDER_RST      = 32'h0000_0000;
  localparam logic [31:0] SWAP_KEY       = 32'hffff_ffff;
  localparam logic        STRAP_BUS16    = 1'b1;

  // Cycles for the strap synchroniser to carry a real sample
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

  // Read sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_HOLD  = 3'b100
  } rd_state_t;

endpackage

// ===== inc/lane_map_if.sv
/*
  Carrier between the port and its half-word lane mapper.
  Assumes both ends sit on the same clock; carries no state.
*/
interface lane_map_if;

  logic bus16;
  logic swap;
  logic a1;
  logic half;

  modport mapper (
    input  bus16,
    input  swap,
    input  a1,
    output half
  );

  modport user (
    output bus16,
    output swap,
    output a1,
    input  half
  );

endinterface
